// ### psw_pkg.sv
//------------------------------------------------------------
// Function
//------------------------------------------------------------
// Function
// - Standard setup: shared pins are inputs; primary access: driver tristate outputs.
// - Input line 3 pin receives data, or outputs 2048 kHz data clock in primary.
// - Overflow raises masked interrupt; status register names the overflowing conference.
// - Interrupt pin only pulls low or floats, for wired-OR sharing.
// - Direct register selects used only in demultiplexed host mode.
// - Host accesses count only while chip select is low.
// - Frame and slot counting aligns to the frame sync pulse.
// - Primary access offers PCM timing shift in half-clock steps.
// - Device clock 4096 or 8192 kHz selectable; bit timing follows it.
// - High reset forces reset state; hold at least four clocks.
// - Strobes sampled only with chip select; write loads on strobe rising edge.
package psw_pkg;
   // Register indexes
   localparam logic [1:0] REG_CONFIG    = 2'h0;
   localparam logic [1:0] REG_CONF_STAT = 2'h1;
   // Configuration field positions
   localparam int CFG_PRIMARY  = 0;
   localparam int CFG_CLK8192  = 1;
   localparam int CFG_SHIFT_LO = 2;
   localparam int CFG_INT_EN   = 5;
   localparam logic [7:0] CFG_RESET = 8'h00;
   // Status field positions
   localparam int STAT_FLAG = 7;
   // Clock rates in kHz
   localparam int DEV_CLK_LO_KHZ  = 4096;
   localparam int DEV_CLK_HI_KHZ  = 8192;
   localparam int DATA_CLK_KHZ    = 2048;
   localparam int FRAME_KHZ       = 8;
   // Half device-clock ticks per frame and per data-clock period
   localparam int FRAME_HALF_LO = 2 * DEV_CLK_LO_KHZ / FRAME_KHZ;
   localparam int FRAME_HALF_HI = 2 * DEV_CLK_HI_KHZ / FRAME_KHZ;
   localparam int DATA_HALF_LO  = 2 * DEV_CLK_LO_KHZ / DATA_CLK_KHZ;
   localparam int DATA_HALF_HI  = 2 * DEV_CLK_HI_KHZ / DATA_CLK_KHZ;
   localparam int RESET_MIN_CYCLES = 4;

   // Whole state of the pin block
   typedef struct packed {
      logic [7:0]  cfg;
      logic [1:0]  addrLatch;
      logic        wrPrev;
      logic        rdPrev;
      logic        devClkPrev;
      logic [10:0] halfCnt;
      logic        ovfFlag;
      logic [4:0]  ovfConf;
      logic        intReqOe_n;
      logic        intReqOut;
      logic [3:0]  sharedOut;
      logic [3:0]  sharedOe_n;
      logic        line3Oe_n;
      logic        line3Out;
      logic [3:0]  pcmIn;
      logic        pcmIn3;
      logic        bitStrobe;
      logic        frameStart;
      logic [7:0]  adOut;
      logic        adOe_n;
   } psw_state_t;
endpackage

// ### psw_pin_config.sv
`timescale 1ns/1ns
module psw_pin_config
(
   input  wire logic       mclk,
   input  wire logic       reset,
   input  wire logic       devClk,
   input  wire logic       frameSyncPulse,
   input  wire logic       csN,
   input  wire logic       rdN,
   input  wire logic       wrN,
   input  wire logic       ale,
   input  wire logic       demuxMode,
   input  wire logic       directRegSel0,
   input  wire logic       directRegSel1,
   input  wire logic [7:0] adIn,
   input  wire logic [3:0] sharedIn,
   input  wire logic       pcmInputLine3In,
   input  wire logic [3:0] lineDriveEn,
   input  wire logic       ovfEvent,
   input  wire logic [4:0] ovfConfNum,
   output logic [7:0]      adOut,
   output logic            adOe_n,
   output logic [3:0]      sharedOut,
   output logic [3:0]      sharedOe_n,
   output logic            line3Out,
   output logic            line3Oe_n,
   output logic [3:0]      pcmIn,
   output logic            pcmIn3,
   output logic            bitStrobe,
   output logic            frameStart,
   output logic            intReqOut,
   output logic            intReqOe_n,
   output logic            primaryMode
);
   psw_pkg::psw_state_t st;
   psw_pkg::psw_state_t next_st;

   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   // Register read value for an index
   function automatic logic [7:0] regRead(input logic [1:0] idx, input psw_pkg::psw_state_t s);
      logic [7:0] v;
      v = 8'h00;
      if (idx == psw_pkg::REG_CONFIG)
         v = s.cfg;
      else if (idx == psw_pkg::REG_CONF_STAT)
         v = {s.ovfFlag, 2'h0, s.ovfConf};
      return v;
   endfunction

   logic [1:0]  regIdx;
   logic [10:0] shifted;
   logic        devEdge;
   logic        wrRise;
   logic        rdRise;
   logic        hiClk;

   //------------------------------------------------------------
   // Combinational decode
   //------------------------------------------------------------
   // Index source and strobe edges
   always_comb
   begin
      regIdx  = demuxMode ? {directRegSel1, directRegSel0} : st.addrLatch;
      devEdge = devClk != st.devClkPrev;   // both edges: half-clock ticks
      wrRise  = wrN && !st.wrPrev && !csN;
      rdRise  = rdN && !st.rdPrev && !csN;
      hiClk   = st.cfg[psw_pkg::CFG_CLK8192];
      shifted = st.halfCnt + {8'h00, st.cfg[psw_pkg::CFG_SHIFT_LO +: 3]};
   end

   //------------------------------------------------------------
   // Next state
   //------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      next_st.wrPrev = wrN;
      next_st.rdPrev = rdN;
      next_st.devClkPrev = devClk;
      next_st.bitStrobe = 1'b0;
      next_st.frameStart = 1'b0;
      // Address latch in multiplexed mode
      if (!demuxMode && ale && !csN)
         next_st.addrLatch = adIn[1:0];
      // Register write on rising write strobe
      if (wrRise && regIdx == psw_pkg::REG_CONFIG)
         next_st.cfg = adIn;
      // Read data drive while selected
      next_st.adOe_n = !(!csN && !rdN);
      next_st.adOut = regRead(regIdx, st);
      // Overflow flag: read clears, new event wins
      if (rdRise && regIdx == psw_pkg::REG_CONF_STAT)
         next_st.ovfFlag = 1'b0;
      if (ovfEvent)
      begin
         next_st.ovfFlag = 1'b1;
         next_st.ovfConf = ovfConfNum;
      end
      // Open-drain request: drive low or float
      next_st.intReqOut = 1'b0;
      next_st.intReqOe_n = !(next_st.ovfFlag && next_st.cfg[psw_pkg::CFG_INT_EN]);
      // Frame counter in half device-clock ticks
      if (devEdge)
      begin
         if (frameSyncPulse && devClk)
         begin
            next_st.halfCnt = 11'h000;
            next_st.frameStart = 1'b1;
         end
         else if (hiClk ? (st.halfCnt == 11'(psw_pkg::FRAME_HALF_HI - 1))
                        : (st.halfCnt == 11'(psw_pkg::FRAME_HALF_LO - 1)))
            next_st.halfCnt = 11'h000;
         else
            next_st.halfCnt = st.halfCnt + 11'h001;
         // Bit strobe at shifted data-clock period start
         next_st.bitStrobe = hiClk ? (shifted[2:0] == 3'h0)
                                   : (shifted[1:0] == 2'h0);
      end
      // Shared pin direction
      if (st.cfg[psw_pkg::CFG_PRIMARY])
      begin
         next_st.sharedOe_n = 4'h0;
         next_st.sharedOut = lineDriveEn;
         next_st.pcmIn = 4'h0;
         next_st.line3Oe_n = 1'b0;
         next_st.line3Out = hiClk ? shifted[2] : shifted[1];
         next_st.pcmIn3 = 1'b0;
      end
      else
      begin
         next_st.sharedOe_n = 4'hf;
         next_st.sharedOut = 4'h0;
         next_st.pcmIn = sharedIn;
         next_st.line3Oe_n = 1'b1;
         next_st.line3Out = 1'b0;
         next_st.pcmIn3 = pcmInputLine3In;
      end
   end

   //------------------------------------------------------------
   // State register
   //------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         st <= '0;
         st.cfg <= psw_pkg::CFG_RESET;
         st.wrPrev <= 1'b1;
         st.rdPrev <= 1'b1;
         st.intReqOe_n <= 1'b1;
         st.sharedOe_n <= 4'hf;
         st.line3Oe_n <= 1'b1;
         st.adOe_n <= 1'b1;
      end
      else
         st <= next_st;
   end

   // Outputs straight from state
   assign adOut = st.adOut;
   assign adOe_n = st.adOe_n;
   assign sharedOut = st.sharedOut;
   assign sharedOe_n = st.sharedOe_n;
   assign line3Out = st.line3Out;
   assign line3Oe_n = st.line3Oe_n;
   assign pcmIn = st.pcmIn;
   assign pcmIn3 = st.pcmIn3;
   assign bitStrobe = st.bitStrobe;
   assign frameStart = st.frameStart;
   assign intReqOut = st.intReqOut;
   assign intReqOe_n = st.intReqOe_n;
   assign primaryMode = st.cfg[psw_pkg::CFG_PRIMARY];

   //------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------
   // Shared pin direction follows the configuration
   shared_dir_a: assert property (@(posedge mclk) disable iff (reset)
      primaryMode |=> (sharedOe_n == 4'h0) && (sharedOut == $past(lineDriveEn)))
      else $error("shared pins not driven in primary mode");
   shared_in_a: assert property (@(posedge mclk) disable iff (reset)
      !primaryMode |=> (sharedOe_n == 4'hf) && (pcmIn == $past(sharedIn)))
      else $error("shared pins not inputs in standard mode");
   // Line 3 pin: data clock out or data in
   line3_clk_a: assert property (@(posedge mclk) disable iff (reset)
      primaryMode && $past(primaryMode) |-> !line3Oe_n)
      else $error("data clock pin not driven");
   line3_std_a: assert property (@(posedge mclk) disable iff (reset)
      !primaryMode |=> line3Oe_n && !line3Out && (pcmIn3 == $past(pcmInputLine3In)))
      else $error("line 3 pin not an input in standard mode");
   // Overflow flag and request pin
   int_raise_a: assert property (@(posedge mclk) disable iff (reset)
      ovfEvent && next_st.cfg[psw_pkg::CFG_INT_EN]
      |=> !intReqOe_n && (st.ovfConf == $past(ovfConfNum)))
      else $error("overflow did not raise request");
   ovf_wins_a: assert property (@(posedge mclk) disable iff (reset)
      ovfEvent |=> st.ovfFlag)
      else $error("overflow event lost to read clear");
   int_od_a: assert property (@(posedge mclk) disable iff (reset)
      intReqOut == 1'b0)
      else $error("request pin driven high");
   // Host access gating
   direct_sel_a: assert property (@(posedge mclk) disable iff (reset)
      demuxMode && !csN && wrN && !st.wrPrev && !directRegSel0 && !directRegSel1
      |=> st.cfg == $past(adIn))
      else $error("direct select write missed");
   cs_gate_a: assert property (@(posedge mclk) disable iff (reset)
      csN |=> adOe_n && $stable(st.cfg))
      else $error("access without chip select");
   // Frame and bit timing, write strobe edge and reset state
   frame_align_a: assert property (@(posedge mclk) disable iff (reset)
      devEdge && devClk && frameSyncPulse |=> st.halfCnt == 11'h000 && frameStart)
      else $error("frame sync not aligned");
   strobe_edge_a: assert property (@(posedge mclk) disable iff (reset)
      !devEdge |=> !bitStrobe && !frameStart)
      else $error("timing pulse without device clock change");
   wr_edge_a: assert property (@(posedge mclk) disable iff (reset)
      !wrN |=> $stable(st.cfg))
      else $error("write loaded before strobe edge");
   reset_std_a: assert property (@(posedge mclk) disable iff (reset)
      $past(reset) |-> !primaryMode && intReqOe_n)
      else $error("reset did not select standard mode");

   // Main scenarios reached
   cov_primary_c: cover property (@(posedge mclk) disable iff (reset) !primaryMode ##1 primaryMode);
   cov_overflow_c: cover property (@(posedge mclk) disable iff (reset) ovfEvent ##1 !intReqOe_n);
   cov_frame_c: cover property (@(posedge mclk) disable iff (reset) frameStart);
   cov_strobe_c: cover property (@(posedge mclk) disable iff (reset) primaryMode && bitStrobe);
   cov_shift_c: cover property (@(posedge mclk) disable iff (reset)
      primaryMode && (st.cfg[psw_pkg::CFG_SHIFT_LO +: 3] != 3'h0) && bitStrobe);
endmodule

// ### psw_far_side.sv
`timescale 1ns/1ns
// Far side: device clock source, frame sync and pulled-up request line
module psw_far_side
(
   mclk,
   run,
   syncReq,
   intReqOut,
   intReqOe_n,
   devClk,
   frameSyncPulse,
   intLine
);
   input  wire logic mclk;
   input  wire logic run;
   input  wire logic syncReq;
   input  wire logic intReqOut;
   input  wire logic intReqOe_n;
   output logic      devClk = 1'b0;
   output logic      frameSyncPulse = 1'b0;
   output wire logic intLine;
   logic             div = 1'b0;
   // Pull-up holds the shared line high unless pulled low
   assign intLine = intReqOe_n ? 1'b1 : intReqOut;
   // Clock stands still while run is low; sync spans one high phase
   always_ff @(posedge mclk)
   begin
      if (run)
      begin
         div <= ~div;
         if (div)
         begin
            devClk <= ~devClk;
            frameSyncPulse <= syncReq & ~devClk;
         end
      end
   end
endmodule

// ### tb_psw_pin_config.sv
`timescale 1ns/1ns
module tb_psw_pin_config;
   logic mclk = 0, reset = 1, csN = 1, rdN = 1, wrN = 1, ale = 0, demuxMode = 1;
   logic sel0 = 0, sel1 = 0, run = 0, syncReq = 0, ovfEvent = 0, line3In = 1;
   logic [7:0] adIn = 8'h00, adOut;
   logic [4:0] ovfConfNum = 5'h00;
   logic [3:0] sharedIn = 4'ha, lineDriveEn = 4'h5, sharedOut, sharedOe_n, pcmIn;
   logic line3Out, line3Oe_n, pcmIn3, bitStrobe, frameStart, intReqOut, intReqOe_n;
   logic adOe_n, primaryMode, devClk, frameSyncPulse, intLine;
   int num_errors = 0, n_tests = 0, cnt, fs, rises;
   logic l3;
   psw_pin_config dut (.mclk(mclk), .reset(reset), .devClk(devClk),
      .frameSyncPulse(frameSyncPulse), .csN(csN), .rdN(rdN), .wrN(wrN), .ale(ale),
      .demuxMode(demuxMode), .directRegSel0(sel0), .directRegSel1(sel1), .adIn(adIn),
      .sharedIn(sharedIn), .pcmInputLine3In(line3In), .lineDriveEn(lineDriveEn),
      .ovfEvent(ovfEvent), .ovfConfNum(ovfConfNum), .adOut(adOut), .adOe_n(adOe_n),
      .sharedOut(sharedOut), .sharedOe_n(sharedOe_n), .line3Out(line3Out),
      .line3Oe_n(line3Oe_n), .pcmIn(pcmIn), .pcmIn3(pcmIn3), .bitStrobe(bitStrobe),
      .frameStart(frameStart), .intReqOut(intReqOut), .intReqOe_n(intReqOe_n),
      .primaryMode(primaryMode));
   psw_far_side far (.mclk(mclk), .run(run), .syncReq(syncReq), .intReqOut(intReqOut),
      .intReqOe_n(intReqOe_n), .devClk(devClk), .frameSyncPulse(frameSyncPulse),
      .intLine(intLine));
   // Clock, 20 ns period
   initial
   begin
      forever #10 mclk = ~mclk;
   end
   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Host write; in mux mode the direct selects carry a wrong index
   task wr(input logic mux, input logic [1:0] idx, input logic [7:0] d, input logic cs);
      @(posedge mclk);
      demuxMode <= ~mux;
      {sel1, sel0} <= mux ? ~idx : idx;
      csN <= ~cs;
      if (mux)
      begin
         ale <= 1'b1;
         adIn <= {6'h00, idx};
         @(posedge mclk);
         ale <= 1'b0;
      end
      wrN <= 1'b0;
      adIn <= d;
      @(posedge mclk);
      wrN <= 1'b1;
      @(posedge mclk);
      csN <= 1'b1;
      demuxMode <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task rd(input logic [1:0] idx, input logic [7:0] exp);
      @(posedge mclk);
      {sel1, sel0} <= idx;
      csN <= 1'b0;
      rdN <= 1'b0;
      repeat (2) @(posedge mclk);
      #1 check({adOe_n, 7'h00}, 8'h00);
      check(adOut, exp);
      @(posedge mclk);
      rdN <= 1'b1;
      @(posedge mclk);
      csN <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task t_modes;
      check({primaryMode, line3Oe_n, sharedOe_n}, 8'h1f);
      check(pcmIn, sharedIn);
      check(pcmIn3, line3In);
      rd(2'h0, 8'h00);
      wr(1'b0, 2'h0, 8'h01, 1'b1);
      check({sharedOe_n, sharedOut}, {4'h0, lineDriveEn});
      check({line3Oe_n, pcmIn, pcmIn3}, 8'h00);
      wr(1'b1, 2'h0, 8'h00, 1'b1);
      check(primaryMode, 1'b0);
      wr(1'b0, 2'h0, 8'h01, 1'b0);
      check(primaryMode, 1'b0);
   endtask
   task t_ovf(input logic [7:0] c, input logic [4:0] n);
      wr(1'b0, 2'h0, c, 1'b1);
      @(posedge mclk);
      ovfEvent <= 1'b1;
      ovfConfNum <= n;
      @(posedge mclk);
      ovfEvent <= 1'b0;
      repeat (2) @(posedge mclk);
      #1 check(intLine, !c[5]);
      rd(2'h1, {3'h4, n});
      check(intLine, 1'b1);
   endtask
   // Count strobes, frame starts and data clock rises over 64 device clock half periods
   task t_clk(input logic [7:0] c, input int exp, input logic s, input int expRise,
              input logic expLast);
      wr(1'b0, 2'h0, c, 1'b1);
      cnt = 0;
      fs = 0;
      rises = 0;
      l3 = line3Out;
      @(posedge mclk);
      run <= 1'b1;
      syncReq <= s;
      repeat (136)
      begin
         @(posedge mclk);
         if (fs == 3) syncReq <= 1'b0;
         if (fs == 127) run <= 1'b0;
         #1;
         cnt += (bitStrobe === 1'b1);
         if (frameStart === 1'b1) cnt += 256;
         rises += (line3Out === 1'b1 && l3 === 1'b0);
         l3 = line3Out;
         fs++;
      end
      check(cnt[7:0], exp[7:0]);
      check(cnt[15:8], {7'h00, s});
      check(rises[7:0], expRise[7:0]);
      check(line3Out, expLast);
   endtask
   task results;
      if (num_errors == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence after an 8-cycle reset
   initial
   begin
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      #1;
      t_modes();
      t_ovf(8'h00, 5'h0a);
      t_ovf(8'h20, 5'h13);
      t_clk(8'h00, 16, 1'b0, 0, 1'b0);
      t_clk(8'h02, 8, 1'b0, 0, 1'b0);
      t_clk(8'h02, 9, 1'b1, 0, 1'b0);
      t_clk(8'h09, 16, 1'b1, 16, 1'b0);
      results();
   end
   // Watchdog
   initial
   begin
      #200000;
      num_errors++;
      results();
   end
endmodule
